/* File: common/cei_pkg.sv */
package cei_pkg;
    // =====================================================
    // register offsets
    localparam logic [7:0] CEI_OFF_ID = 8'h00;
    localparam logic [7:0] CEI_OFF_REF_FLAGS = 8'h02;
    localparam logic [7:0] CEI_OFF_LOOP_FLAGS = 8'h03;
    localparam logic [7:0] CEI_OFF_REF_EN = 8'h04;
    localparam logic [7:0] CEI_OFF_LOOP_EN = 8'h05;
    localparam logic [7:0] CEI_OFF_MON_UPPER = 8'h06;
    localparam logic [7:0] CEI_OFF_MON_LOWER = 8'h07;

    // =====================================================
    // identification fields
    localparam int CEI_PART_LSB = 0;
    localparam int CEI_PART_W = 5;
    localparam int CEI_REV_LSB = 5;
    localparam int CEI_REV_W = 2;
    localparam int CEI_READY_BIT = 7;
    // arbitrary values, not any real part
    localparam logic [4:0] CEI_PART_CODE = 5'h1a;
    localparam logic [1:0] CEI_REV_CODE = 2'h1;

    // =====================================================
    // field widths and reset values
    localparam int CEI_REF_N = 4;
    localparam int CEI_LOOP_EV_N = 4;
    localparam int CEI_MON_N = 16;
    localparam logic [7:0] CEI_FLAGS_RST = 8'h00;
    localparam logic [7:0] CEI_EN_RST = 8'h00;
    localparam logic [7:0] CEI_UNMAPPED = 8'h00;

    // =====================================================
    // ready timing: longest time rounds down
    localparam int CEI_MCLK_HZ = 25_000_000;
    localparam int CEI_READY_MAX_MS = 50;
    localparam int CEI_HOST_POLL_MS = 40;
    localparam int CEI_READY_CYCLES = CEI_READY_MAX_MS * (CEI_MCLK_HZ / 1000);
    // reset sync plus output stage ahead of the count
    localparam int CEI_READY_LATENCY = 4;
endpackage

/* File: rtl/cei_sticky_bank.sv */
`timescale 1ns/1ps
module cei_sticky_bank #(
    parameter int WIDTH = 4
) (
    input wire logic clk, // core clock
    input wire logic rst_n, // synchronised reset
    input wire logic [WIDTH-1:0] evt, // event levels
    input wire logic [WIDTH-1:0] en, // per-bit set enable
    input wire logic [WIDTH-1:0] clr, // write-one clear
    output logic [WIDTH-1:0] flagQ // sticky flags
);
    // =====================================================
    // per-bit sticky flag, set beats clear
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++)
        begin : g_bit
            always_ff @(posedge clk or negedge rst_n)
            begin
                if (!rst_n)
                    flagQ[i] <= 1'b0;
                else if (evt[i] && en[i])
                    flagQ[i] <= 1'b1;
                else if (clr[i])
                    flagQ[i] <= 1'b0;
            end
        end
    endgenerate
endmodule // cei_sticky_bank

/* File: rtl/cei_event_irq.sv */
`timescale 1ns/1ps
module cei_event_irq
    import cei_pkg::*;
#(
    parameter int READY_CYCLES = CEI_READY_CYCLES
) (
    input wire logic mclk, // core clock 25 MHz
    input wire logic reset_n, // async reset, active low
    input wire logic [7:0] regAddr, // register address
    input wire logic regWrite, // write strobe
    input wire logic regRead, // read strobe
    input wire logic [7:0] regWrData, // write data
    output logic [7:0] regRdData, // read data, next cycle
    output logic regRdValid, // read data valid pulse
    input wire logic [CEI_REF_N-1:0] refFail, // input failure levels
    input wire logic [1:0] loopHoldover, // loop holdover levels
    input wire logic [1:0] loopUnlock, // loop unlock levels
    input wire logic [CEI_MON_N-1:0] monFail, // monitor indicator levels
    output logic irqQ, // interrupt request
    output logic readyQ // device ready
);
    localparam int CW = $clog2(READY_CYCLES + 1);
    localparam logic [CW-1:0] READY_LAST = CW'(READY_CYCLES - CEI_READY_LATENCY);

    // =====================================================
    // reset release
    logic rstMeta_n;
    logic rst_n;
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rstMeta_n <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rstMeta_n <= 1'b1;
            rst_n <= rstMeta_n;
        end
    end

    // =====================================================
    // ready timer
    logic [CW-1:0] readyCnt_q;
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            readyCnt_q <= '0;
        else if (readyCnt_q != READY_LAST)
            readyCnt_q <= readyCnt_q + 1'b1;
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            readyQ <= 1'b0;
        else if (readyCnt_q == READY_LAST)
            readyQ <= 1'b1;
    end

    // =====================================================
    // enable registers
    logic [CEI_REF_N-1:0] refEn_q;
    logic [CEI_LOOP_EV_N-1:0] loopEn_q;
    logic wrRefEn;
    logic wrLoopEn;
    assign wrRefEn = regWrite && (regAddr == CEI_OFF_REF_EN);
    assign wrLoopEn = regWrite && (regAddr == CEI_OFF_LOOP_EN);

    // upper bits not stored; host keeps them zero
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            refEn_q <= CEI_EN_RST[CEI_REF_N-1:0];
            loopEn_q <= CEI_EN_RST[CEI_LOOP_EV_N-1:0];
        end
        else
        begin
            if (wrRefEn)
                refEn_q <= regWrData[CEI_REF_N-1:0];
            if (wrLoopEn)
                loopEn_q <= regWrData[CEI_LOOP_EV_N-1:0];
        end
    end

    // =====================================================
    // sticky flags, write one to clear
    logic [CEI_REF_N-1:0] refFlags;
    logic [CEI_LOOP_EV_N-1:0] loopFlags;
    logic [CEI_MON_N-1:0] monFlags;
    logic [CEI_REF_N-1:0] refClr;
    logic [CEI_LOOP_EV_N-1:0] loopClr;
    logic [CEI_MON_N-1:0] monClr;
    logic [CEI_LOOP_EV_N-1:0] loopEvt;

    // bit 0 holdover, bit 1 unlock
    // loop 1 in bits 2 and 3
    assign loopEvt = {loopUnlock[1], loopHoldover[1], loopUnlock[0], loopHoldover[0]};
    assign refClr = (regWrite && regAddr == CEI_OFF_REF_FLAGS)
                    ? regWrData[CEI_REF_N-1:0] : '0;
    assign loopClr = (regWrite && regAddr == CEI_OFF_LOOP_FLAGS)
                     ? regWrData[CEI_LOOP_EV_N-1:0] : '0;
    assign monClr[7:0] = (regWrite && regAddr == CEI_OFF_MON_LOWER) ? regWrData : 8'h00;
    assign monClr[15:8] = (regWrite && regAddr == CEI_OFF_MON_UPPER) ? regWrData : 8'h00;

    cei_sticky_bank #(.WIDTH(CEI_REF_N)) uRef (
        .clk(mclk),
        .rst_n(rst_n),
        .evt(refFail),
        .en(refEn_q),
        .clr(refClr),
        .flagQ(refFlags)
    );

    cei_sticky_bank #(.WIDTH(CEI_LOOP_EV_N)) uLoop (
        .clk(mclk),
        .rst_n(rst_n),
        .evt(loopEvt),
        .en(loopEn_q),
        .clr(loopClr),
        .flagQ(loopFlags)
    );

    cei_sticky_bank #(.WIDTH(CEI_MON_N)) uMon (
        .clk(mclk),
        .rst_n(rst_n),
        .evt(monFail),
        .en({CEI_MON_N{1'b1}}),
        .clr(monClr),
        .flagQ(monFlags)
    );

    // =====================================================
    // interrupt request
    // any enabled input or loop flag raises; monitor flags never do
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            irqQ <= 1'b0;
        else
            irqQ <= (|(refFlags & refEn_q)) || (|(loopFlags & loopEn_q));
    end

    // =====================================================
    // register read, one cycle latency
    logic [7:0] rdMux;
    always_comb
    begin
        case (regAddr)
            CEI_OFF_ID: rdMux = {readyQ, CEI_REV_CODE, CEI_PART_CODE};
            CEI_OFF_REF_FLAGS: rdMux = {CEI_FLAGS_RST[7:CEI_REF_N], refFlags};
            CEI_OFF_LOOP_FLAGS: rdMux = {CEI_FLAGS_RST[7:CEI_LOOP_EV_N], loopFlags};
            CEI_OFF_REF_EN: rdMux = {CEI_EN_RST[7:CEI_REF_N], refEn_q};
            CEI_OFF_LOOP_EN: rdMux = {CEI_EN_RST[7:CEI_LOOP_EV_N], loopEn_q};
            CEI_OFF_MON_UPPER: rdMux = monFlags[15:8];
            CEI_OFF_MON_LOWER: rdMux = monFlags[7:0];
            default: rdMux = CEI_UNMAPPED;
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            regRdData <= 8'h00;
            regRdValid <= 1'b0;
        end
        else
        begin
            regRdValid <= regRead;
            if (regRead)
                regRdData <= rdMux;
        end
    end

    // =====================================================
    // checks
    ready_rise_a: assert property (@(posedge mclk) disable iff (!rst_n)
        $rose(readyQ) |-> $past(readyCnt_q) == READY_LAST)
        else $error("ready rose at wrong count");

    ready_bound_a: assert property (@(posedge mclk) disable iff (!rst_n)
        readyCnt_q == READY_LAST |=> readyQ)
        else $error("ready not high at end of wait");

    id_read_a: assert property (@(posedge mclk) disable iff (!rst_n)
        regRead && regAddr == CEI_OFF_ID |=>
        regRdValid && regRdData[6:0] == {CEI_REV_CODE, CEI_PART_CODE})
        else $error("id readback wrong");

    ref_set_a: assert property (@(posedge mclk) disable iff (!rst_n)
        |(refFail & refEn_q) |=>
        ((refFlags & $past(refFail & refEn_q)) == $past(refFail & refEn_q)))
        else $error("enabled input failure not flagged");

    ref_mask_a: assert property (@(posedge mclk) disable iff (!rst_n)
        ##1 ((refFlags & ~$past(refFlags) & ~$past(refEn_q)) == '0))
        else $error("disabled input flag was set");

    loop_set_a: assert property (@(posedge mclk) disable iff (!rst_n)
        |(loopEvt & loopEn_q) |=>
        ((loopFlags & $past(loopEvt & loopEn_q)) == $past(loopEvt & loopEn_q)))
        else $error("enabled loop event not flagged");

    loop_mask_a: assert property (@(posedge mclk) disable iff (!rst_n)
        ##1 ((loopFlags & ~$past(loopFlags) & ~$past(loopEn_q)) == '0))
        else $error("disabled loop flag was set");

    irq_follow_a: assert property (@(posedge mclk) disable iff (!rst_n)
        ((|(refFlags & refEn_q)) || (|(loopFlags & loopEn_q))) |=> irqQ)
        else $error("interrupt missing for enabled flag");

    irq_quiet_a: assert property (@(posedge mclk) disable iff (!rst_n)
        !((|(refFlags & refEn_q)) || (|(loopFlags & loopEn_q))) |=> !irqQ)
        else $error("interrupt without enabled flag");

    mon_set_a: assert property (@(posedge mclk) disable iff (!rst_n)
        |monFail |=> ((monFlags & $past(monFail)) == $past(monFail)))
        else $error("monitor indicator not flagged");

    ref_sticky_a: assert property (@(posedge mclk) disable iff (!rst_n)
        |refFlags |=>
        ((refFlags & $past(refFlags & ~refClr)) == $past(refFlags & ~refClr)))
        else $error("input flag dropped without clear");
endmodule // cei_event_irq

/* File: dv/cei_host_model.sv */
`timescale 1ns/1ps
module cei_host_model (
    input wire logic mclk, // core clock
    input wire logic readyQ, // device ready
    input wire logic [7:0] regRdData, // read data
    input wire logic regRdValid, // read valid pulse
    output logic [7:0] regAddr, // address
    output logic regWrite, // write strobe
    output logic regRead, // read strobe
    output logic [7:0] regWrData // write data
);
    initial
    begin
        regAddr = 8'hff;
        regWrite = 1'b0;
        regRead = 1'b0;
        regWrData = 8'hff;
    end

    task automatic waitReady(input int limit, output int n);
        n = 0;
        while (readyQ !== 1'b1 && n < limit)
        begin
            @(posedge mclk);
            #1;
            n++;
        end
    endtask

    // idle bus shows inverted values, never a stale copy
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        #1;
        regAddr = a;
        regWrData = d;
        regWrite = 1'b1;
        @(posedge mclk);
        #1;
        regWrite = 1'b0;
        regAddr = ~a;
        regWrData = ~d;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
        @(posedge mclk);
        #1;
        regAddr = a;
        regRead = 1'b1;
        @(posedge mclk);
        #1;
        // valid pulse stands for this one cycle only
        v = regRdValid;
        d = regRdData;
        regRead = 1'b0;
        regAddr = ~a;
    endtask
endmodule // cei_host_model

/* File: dv/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    import cei_pkg::*;
    // short ready count keeps the run brief
    localparam int RC = 16;
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] regAddr, regWrData, regRdData;
    logic regWrite, regRead, regRdValid, irqQ, readyQ;
    logic [3:0] refFail = 4'h0;
    logic [1:0] loopHoldover = 2'h0;
    logic [1:0] loopUnlock = 2'h0;
    logic [15:0] monFail = 16'h0;
    int errors = 0;
    int checks = 0;
    int n;

    always #20 mclk = ~mclk;

    cei_event_irq #(.READY_CYCLES(RC)) uut (.mclk(mclk), .reset_n(reset_n),
        .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead),
        .regWrData(regWrData), .regRdData(regRdData), .regRdValid(regRdValid),
        .refFail(refFail), .loopHoldover(loopHoldover), .loopUnlock(loopUnlock),
        .monFail(monFail), .irqQ(irqQ), .readyQ(readyQ));

    cei_host_model uHost (.mclk(mclk), .readyQ(readyQ), .regRdData(regRdData),
        .regRdValid(regRdValid), .regAddr(regAddr), .regWrite(regWrite),
        .regRead(regRead), .regWrData(regWrData));

    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e)
        begin
            $display("wrong value %s expected %h seen %h", nm, e, g);
            errors++;
        end
    endtask

    task automatic rdChk(input logic [7:0] a, input logic [7:0] e, input string nm);
        logic [7:0] d;
        logic v;
        uHost.rd(a, d, v);
        chk("read valid", 8'h01, {7'h0, v});
        chk(nm, e, d);
    endtask

    task automatic evt(input logic [3:0] r, input logic [1:0] h, input logic [1:0] u,
        input logic [15:0] m);
        @(posedge mclk);
        #1;
        refFail = r;
        loopHoldover = h;
        loopUnlock = u;
        monFail = m;
        @(posedge mclk);
        #1;
        refFail = 4'h0;
        loopHoldover = 2'h0;
        loopUnlock = 2'h0;
        monFail = 16'h0;
    endtask

    task automatic report_and_stop;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    initial
    begin
        repeat (12) @(posedge mclk);
        #1;
        reset_n = 1'b1;
        chk("ready early", 8'h00, {7'h0, readyQ});
        uHost.waitReady(RC, n);
        chk("ready in time", 8'h01, {7'h0, readyQ});
        uHost.wr(CEI_OFF_ID, 8'h00);
        rdChk(CEI_OFF_ID, {1'b1, CEI_REV_CODE, CEI_PART_CODE}, "id");
        rdChk(8'h01, CEI_UNMAPPED, "unmapped");
        $display("test reset and id done");
        // both enable registers still zero here
        evt(4'hf, 2'h3, 2'h3, 16'h0);
        rdChk(CEI_OFF_REF_FLAGS, 8'h00, "masked ref");
        rdChk(CEI_OFF_LOOP_FLAGS, 8'h00, "masked loop");
        chk("masked irq", 8'h00, {7'h0, irqQ});
        $display("test masked events done");
        for (int i = 0; i < 4; i++)
        begin
            logic [3:0] lv;
            lv = 4'h1 << i;
            uHost.wr(CEI_OFF_REF_EN, 8'h01 << i);
            uHost.wr(CEI_OFF_LOOP_EN, 8'h00);
            // one input only, so a crossed mapping shows
            evt(lv, 2'h3, 2'h3, 16'h0);
            rdChk(CEI_OFF_REF_FLAGS, 8'h01 << i, "ref flag");
            chk("ref irq", 8'h01, {7'h0, irqQ});
            uHost.wr(CEI_OFF_REF_FLAGS, 8'h01 << i);
            rdChk(CEI_OFF_REF_FLAGS, 8'h00, "ref clear");
            chk("ref irq clear", 8'h00, {7'h0, irqQ});
            // input enables off before the loop phase, else the input flag sets again
            uHost.wr(CEI_OFF_REF_EN, 8'h00);
            uHost.wr(CEI_OFF_LOOP_EN, 8'h01 << i);
            evt(4'hf, {lv[2], lv[0]}, {lv[3], lv[1]}, 16'h0);
            rdChk(CEI_OFF_LOOP_FLAGS, 8'h01 << i, "loop flag");
            rdChk(CEI_OFF_REF_FLAGS, 8'h00, "ref masked");
            chk("loop irq", 8'h01, {7'h0, irqQ});
            uHost.wr(CEI_OFF_LOOP_FLAGS, 8'h01 << i);
            rdChk(CEI_OFF_LOOP_FLAGS, 8'h00, "loop clear");
            chk("loop irq clear", 8'h00, {7'h0, irqQ});
        end
        rdChk(CEI_OFF_LOOP_EN, 8'h08, "loop enables");
        $display("test enabled events done");
        evt(4'h0, 2'h0, 2'h0, 16'ha53c);
        rdChk(CEI_OFF_MON_LOWER, 8'h3c, "mon lower");
        rdChk(CEI_OFF_MON_UPPER, 8'ha5, "mon upper");
        chk("mon irq", 8'h00, {7'h0, irqQ});
        $display("test monitor flags done");
        report_and_stop();
    end

    initial
    begin
        #(40 * 3000);
        errors++;
        $display("watchdog expired");
        report_and_stop();
    end
endmodule // tb_top
